//--- hw/srl_latch_unit.sv
// Set-reset latch unit with selectable sources and APB control.
// Assumes one 20 MHz clock; comparator, input pin and timer clock are async.
//
// Behaviour
// - Latch holds state; sources active high
// - Reset beats set when both active
// - Software set/reset bits clear themselves
// - Comparator selectable as set and reset
// - Comparator optionally resampled on timer clock
// - Input pin selectable as set and reset
// - Divider ratio 4 to 512, doubling
// - Separate enables route pulse to set/reset
// - True and inverted outputs enabled separately
// - Device reset leaves latch state undefined
// - Divided pulse lasts one clock
// - Software set pulses one clock, reads zero
// - Pins driven only with latch enable set
`default_nettype none
module srl_latch_unit (
  input  wire logic                       mclk_in,      // 20 MHz clock
  input  wire logic                       reset_n_in,   // Async reset, active low
  input  wire logic                       psel_in,      // APB select
  input  wire logic                       penable_in,   // APB enable
  input  wire logic                       pwrite_in,    // APB direction
  input  wire logic [srl_pkg::ADDR_W-1:0] paddr_in,     // APB address
  input  wire logic [srl_pkg::DATA_W-1:0] pwdata_in,    // APB write data
  output logic      [srl_pkg::DATA_W-1:0] prdata_out,   // APB read data
  output logic                            pready_out,   // APB ready
  output logic                            pslverr_out,  // APB error
  input  wire logic                       comp_out_in,  // Comparator output
  input  wire logic                       ext_pin_in,   // External latch input
  input  wire logic                       timer1_clk_in, // Timer clock source
  output logic                            true_pin_out, // True output level
  output logic                            true_drv_out, // True output drive
  output logic                            inv_pin_out,  // Inverted output level
  output logic                            inv_drv_out   // Inverted output drive
);
  srl_pkg::srl_ctrl0_t ctrl0_q;
  srl_pkg::srl_ctrl1_t ctrl1_q;
  logic                sync_en_q;
  logic                soft_set_q;
  logic                soft_rst_q;
  logic                latch_q;
  logic                latch_d;
  logic                t1_prev_q;
  logic                comp_t1_q;
  logic [srl_pkg::DATA_W-1:0] rdata_q;
  logic                slverr_q;
  logic [srl_pkg::SYNC_W-1:0] sync_s;
  logic                ext_s;
  logic                comp_s;
  logic                t1_s;
  logic                comp_sel;
  logic                pulse;
  logic                set_src;
  logic                rst_src;
  logic                setup_ph;
  logic                wr_en;
  logic                hit_c0;
  logic                hit_c1;
  logic                hit_sy;
  logic                hit_st;
  srl_pkg::srl_pin_t   true_pin;
  srl_pkg::srl_pin_t   inv_pin;
  logic                known_q;
  srl_pkg::srl_ctrl0_t wr_c0;

  srl_sync2 #(
    .W (srl_pkg::SYNC_W)
  ) u_sync (
    .clk_in     (mclk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({timer1_clk_in, comp_out_in, ext_pin_in}),
    .sync_out   (sync_s)
  );

  assign ext_s  = sync_s[srl_pkg::SYNC_EXT_BIT];
  assign comp_s = sync_s[srl_pkg::SYNC_CMP_BIT];
  assign t1_s   = sync_s[srl_pkg::SYNC_T1_BIT];

  srl_pulse_div u_div (
    .clk_in     (mclk_in),
    .reset_n_in (reset_n_in),
    .sel_in     (ctrl0_q.pulse_divider_select),
    .pulse_out  (pulse)
  );

  // APB decode; zero wait states
  assign setup_ph = psel_in && !penable_in;
  assign wr_en    = psel_in && penable_in && pwrite_in;
  assign hit_c0   = (paddr_in == srl_pkg::OFF_CTRL0);
  assign hit_c1   = (paddr_in == srl_pkg::OFF_CTRL1);
  assign hit_sy   = (paddr_in == srl_pkg::OFF_SYNC);
  assign hit_st   = (paddr_in == srl_pkg::OFF_STATUS);
  assign pready_out = 1'b1;
  assign wr_c0      = pwdata_in[7:0];

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ctrl0_q <= srl_pkg::CTRL0_RST;
    else if (wr_en && hit_c0)
    begin
      ctrl0_q <= pwdata_in[7:0];
      ctrl0_q.soft_set_pulse_bit   <= 1'b0;
      ctrl0_q.soft_reset_pulse_bit <= 1'b0;
    end
  end

  // Held-clear bits are not stored
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ctrl1_q <= srl_pkg::CTRL1_RST;
    else if (wr_en && hit_c1)
    begin
      ctrl1_q <= pwdata_in[7:0];
      ctrl1_q.held_clear_hi <= 1'b0;
      ctrl1_q.held_clear_lo <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sync_en_q <= srl_pkg::SYNC_RST;
    else if (wr_en && hit_sy)
      sync_en_q <= pwdata_in[srl_pkg::SYNC_EN_BIT];
  end

  // One-clock software pulses
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      soft_set_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      soft_set_q <= wr_en && hit_c0 && wr_c0.soft_set_pulse_bit;
      soft_rst_q <= wr_en && hit_c0 && wr_c0.soft_reset_pulse_bit;
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_q  <= '0;
      slverr_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      rdata_q  <= '0;
      slverr_q <= !(hit_c0 || hit_c1 || hit_sy || hit_st);
      if (hit_c0)
      begin
        rdata_q[7:0] <= ctrl0_q;
        rdata_q[1:0] <= 2'h0;
      end
      else if (hit_c1)
        rdata_q[7:0] <= ctrl1_q;
      else if (hit_sy)
        rdata_q[srl_pkg::SYNC_EN_BIT] <= sync_en_q;
      else if (hit_st)
        rdata_q[srl_pkg::STAT_Q_BIT] <= latch_q;
    end
  end

  assign prdata_out  = rdata_q;
  assign pslverr_out = slverr_q;

  // Comparator resampled on timer clock rising edge
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      t1_prev_q <= 1'b0;
      comp_t1_q <= 1'b0;
    end
    else
    begin
      t1_prev_q <= t1_s;
      if (t1_s && !t1_prev_q)
        comp_t1_q <= comp_s;
    end
  end

  assign comp_sel = sync_en_q ? comp_t1_q : comp_s;

  assign set_src = soft_set_q
                 || (ctrl1_q.comp_to_set_enable && comp_sel)
                 || (ctrl1_q.pin_to_set_enable && ext_s)
                 || (ctrl1_q.pulse_to_set_enable && pulse);
  assign rst_src = soft_rst_q
                 || (ctrl1_q.comp_to_reset_enable && comp_sel)
                 || (ctrl1_q.pin_to_reset_enable && ext_s)
                 || (ctrl1_q.pulse_to_reset_enable && pulse);

  always_comb
  begin
    latch_d = latch_q;
    if (rst_src)
      latch_d = 1'b0;
    else if (set_src)
      latch_d = 1'b1;
  end

  // No reset: state is undefined until a set or reset source acts
  always_ff @(posedge mclk_in)
  begin
    latch_q <= latch_d;
  end

  // Latch known once any source acts; gates the hold and complement checks
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      known_q <= 1'b0;
    else if (set_src || rst_src)
      known_q <= 1'b1;
  end

  always_comb
  begin
    true_pin.level = latch_q;
    true_pin.drive = ctrl0_q.latch_enable_bit && ctrl0_q.true_output_enable;
    inv_pin.level  = !latch_q;
    inv_pin.drive  = ctrl0_q.latch_enable_bit && ctrl0_q.inverted_output_enable;
  end

  assign true_pin_out = true_pin.level;
  assign true_drv_out = true_pin.drive;
  assign inv_pin_out  = inv_pin.level;
  assign inv_drv_out  = inv_pin.drive;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_soft_set_write;
    wr_en && hit_c0 && wr_c0.soft_set_pulse_bit;
  endsequence

  sequence s_soft_rst_write;
    wr_en && hit_c0 && wr_c0.soft_reset_pulse_bit;
  endsequence

  sequence s_one_rst_pulse;
    soft_rst_q ##1 !soft_rst_q;
  endsequence

  sequence s_one_pulse;
    soft_set_q ##1 !soft_set_q;
  endsequence

  chk_reset_wins: assert property (rst_src |=> !latch_q)
    else $error("Latch not reset when reset source active");
  chk_set_takes: assert property (set_src && !rst_src |=> latch_q)
    else $error("Latch not set by active set source");
  chk_hold_idle: assert property (known_q && !set_src && !rst_src |=> $stable(latch_q))
    else $error("Latch changed with no source active");
  chk_soft_set_pulse: assert property (s_soft_set_write |=> s_one_pulse)
    else $error("Software set not a single clock pulse");
  chk_soft_read_zero: assert property (psel_in && penable_in && !pwrite_in
                                       && hit_c0 |-> prdata_out[1:0] == 2'h0)
    else $error("Software pulse bits read back nonzero");
  chk_div_ratio_min: assert property (pulse && ctrl0_q.pulse_divider_select == 3'h0
                                      |-> ##1 !pulse[*3] ##1 pulse)
    else $error("Smallest divide ratio is not four");
  chk_div_width: assert property (pulse |=> !pulse)
    else $error("Divided pulse wider than one clock");
  chk_pin_sets: assert property (ctrl1_q.pin_to_set_enable && ext_s && !rst_src
                                 |=> latch_q)
    else $error("Input pin did not set latch");
  chk_comp_resets: assert property (ctrl1_q.comp_to_reset_enable && comp_sel
                                    |=> !latch_q)
    else $error("Comparator did not reset latch");
  chk_pulse_resets: assert property (ctrl1_q.pulse_to_reset_enable && pulse
                                     |=> !latch_q)
    else $error("Divided pulse did not reset latch");
  chk_pin_gating: assert property (!ctrl0_q.latch_enable_bit
                                   |-> !true_drv_out && !inv_drv_out)
    else $error("Output driven while latch disabled");
  chk_out_invert: assert property (known_q |-> true_pin_out != inv_pin_out)
    else $error("Outputs not complementary");
  chk_t1_sample: assert property (sync_en_q && t1_s && !t1_prev_q
                                  |=> comp_sel == $past(comp_s))
    else $error("Comparator not resampled on timer edge");
  chk_soft_rst_pulse: assert property (s_soft_rst_write |=> s_one_rst_pulse)
    else $error("Software reset not a single clock pulse");
  chk_comp_sets: assert property (ctrl1_q.comp_to_set_enable && comp_sel && !rst_src
                                  |=> latch_q)
    else $error("Comparator did not set latch");
  chk_pin_resets: assert property (ctrl1_q.pin_to_reset_enable && ext_s
                                   |=> !latch_q)
    else $error("Input pin did not reset latch");
  chk_pulse_sets: assert property (ctrl1_q.pulse_to_set_enable && pulse && !rst_src
                                   |=> latch_q)
    else $error("Divided pulse did not set latch");
endmodule
`default_nettype wire

//--- hw/srl_pkg.sv
// Shared constants and types for the set-reset latch unit.
// Assumes a 20 MHz system clock and an APB register bus.
`default_nettype none
package srl_pkg;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned CNT_W   = 9;
  localparam int unsigned SYNC_W  = 3;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_CTRL0  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFF_CTRL1  = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] OFF_SYNC   = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 32'h0000_000C;

  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic       SYNC_RST  = 1'b0;

  // Field positions outside the packed control words
  localparam int unsigned SYNC_EN_BIT  = 0;
  localparam int unsigned STAT_Q_BIT   = 0;
  localparam int unsigned SYNC_EXT_BIT = 0;
  localparam int unsigned SYNC_CMP_BIT = 1;
  localparam int unsigned SYNC_T1_BIT  = 2;

  // Smallest divide ratio is 2 to this power
  localparam logic [3:0] DIV_BASE_SHIFT = 4'h2;

  typedef struct packed {
    logic             latch_enable_bit;
    logic [SEL_W-1:0] pulse_divider_select;
    logic             true_output_enable;
    logic             inverted_output_enable;
    logic             soft_set_pulse_bit;
    logic             soft_reset_pulse_bit;
  } srl_ctrl0_t;

  typedef struct packed {
    logic pin_to_set_enable;
    logic pulse_to_set_enable;
    logic held_clear_hi;
    logic comp_to_set_enable;
    logic pin_to_reset_enable;
    logic pulse_to_reset_enable;
    logic held_clear_lo;
    logic comp_to_reset_enable;
  } srl_ctrl1_t;

  typedef struct packed {
    logic drive;
    logic level;
  } srl_pin_t;
endpackage
`default_nettype wire

//--- hw/srl_pulse_div.sv
// Free-running divider giving a one-cycle pulse every 4 to 512 clocks.
// Assumes the select input comes from a register on the same clock.
`default_nettype none
module srl_pulse_div (
  input  wire logic                     clk_in,     // System clock
  input  wire logic                     reset_n_in, // Async reset, active low
  input  wire logic [srl_pkg::SEL_W-1:0] sel_in,    // Ratio select
  output logic                          pulse_out   // One-cycle pulse
);
  logic [srl_pkg::CNT_W-1:0] cnt_q;

  function automatic logic [srl_pkg::CNT_W-1:0] last_count(
    input logic [srl_pkg::SEL_W-1:0] sel
  );
    logic [3:0] shift;
    shift = 4'(sel) + srl_pkg::DIV_BASE_SHIFT;
    return srl_pkg::CNT_W'((10'h001 << shift) - 10'h001);
  endfunction

  // Ratio is sampled only at the wrap
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cnt_q <= '0;
    else if (cnt_q == '0)
      cnt_q <= last_count(sel_in);
    else
      cnt_q <= cnt_q - srl_pkg::CNT_W'(1);
  end

  assign pulse_out = (cnt_q == '0);
endmodule
`default_nettype wire

//--- hw/srl_sync2.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs may change at any time relative to clk_in.
`default_nettype none
module srl_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,     // System clock
  input  wire logic         reset_n_in, // Async reset, active low
  input  wire logic [W-1:0] async_in,   // Levels from pins
  output logic      [W-1:0] sync_out    // Synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

//--- tb/srl_far_model.sv
// Far-side stand-in: comparator level, latch input pin and timer clock.
// Assumes the bench sets the levels; the timer clock runs only when enabled.
`default_nettype none
module srl_far_model (
  input  wire logic cmp_lvl_in,  // Wanted comparator level
  input  wire logic pin_lvl_in,  // Wanted pin level
  input  wire logic tclk_run_in, // Timer clock enable
  output logic      comp_out,    // Comparator output
  output logic      ext_pin_out, // Latch input pin
  output logic      tclk_out     // Timer clock source
);
  timeunit 1ns;
  timeprecision 1ps;
  assign comp_out    = cmp_lvl_in;
  assign ext_pin_out = pin_lvl_in;
  // Unrelated period; stands low while stopped
  always #65 tclk_out = tclk_run_in ? ~tclk_out : 1'b0;
endmodule
`default_nettype wire

//--- tb/tb_set_reset_latch_unit.sv
// Directed testbench for the set-reset latch unit over APB.
// Assumes the far-side model supplies comparator, pin and timer clock.
`default_nettype none
module tb_set_reset_latch_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in    = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] paddr      = 32'h0000_0000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic        cmp_lvl    = 1'b0;
  logic        pin_lvl    = 1'b0;
  logic        trun       = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        comp;
  logic        ext;
  logic        tclk;
  logic        tq;
  logic        tdrv;
  logic        iq;
  logic        idrv;
  int          errors      = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          t1;
  int          p;
  int          d;
  int          c [2];
  logic [7:0]  en_tab [5]  = '{8'h88, 8'h84, 8'h8C, 8'h0C, 8'h80};
  logic [7:0]  sc [6]      = '{8'h10, 8'h01, 8'h80, 8'h08, 8'h18, 8'h04};
  logic [1:0]  sk [6]      = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
  logic        se [6]      = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc <= cyc + 1;

  srl_far_model far_u (
    .cmp_lvl_in  (cmp_lvl),
    .pin_lvl_in  (pin_lvl),
    .tclk_run_in (trun),
    .comp_out    (comp),
    .ext_pin_out (ext),
    .tclk_out    (tclk)
  );

  srl_latch_unit dut_u (
    .mclk_in       (mclk_in),
    .reset_n_in    (reset_n_in),
    .psel_in       (psel),
    .penable_in    (penable),
    .pwrite_in     (pwrite),
    .paddr_in      (paddr),
    .pwdata_in     (pwdata),
    .prdata_out    (prdata),
    .pready_out    (pready),
    .pslverr_out   (pslverr),
    .comp_out_in   (comp),
    .ext_pin_in    (ext),
    .timer1_clk_in (tclk),
    .true_pin_out  (tq),
    .true_drv_out  (tdrv),
    .inv_pin_out   (iq),
    .inv_drv_out   (idrv)
  );

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dat,
                     output logic err);
    int n;
    @(posedge mclk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      errors++;
      test_done();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    logic e;
    apb(1'b1, a, dat, e);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp,
                       input logic experr);
    logic e;
    apb(1'b0, a, 32'h0000_0000, e);
    chk(what, exp, rd);
    chk({what, " error"}, 32'(experr), 32'(e));
  endtask

  task automatic wait_q(input logic exp, input int lim, output int t);
    t = 0;
    while (tq !== exp && t < lim)
    begin
      @(negedge mclk_in);
      t++;
    end
    chk("latch", 32'(exp), 32'(tq));
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk_in);
    errors++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    chk("drive after reset", 32'h0000_0000, 32'({tdrv, idrv}));
    rdchk("ctrl0", srl_pkg::OFF_CTRL0, 32'h0000_0000, 1'b0);
    rdchk("ctrl1", srl_pkg::OFF_CTRL1, 32'h0000_0000, 1'b0);
    rdchk("sync", srl_pkg::OFF_SYNC, 32'h0000_0000, 1'b0);
    rdchk("unmapped", 32'h0000_0010, 32'h0000_0000, 1'b1);
    wr(32'h0000_0010, 32'h0000_00FF);
    rdchk("ctrl0 kept", srl_pkg::OFF_CTRL0, 32'h0000_0000, 1'b0);
    wr(srl_pkg::OFF_CTRL0, 32'h0000_0002);
    wait_q(1'b1, 8, t1);
    rdchk("set bit", srl_pkg::OFF_CTRL0, 32'h0000_0000, 1'b0);
    rdchk("status", srl_pkg::OFF_STATUS, 32'h0000_0001, 1'b0);
    wr(srl_pkg::OFF_CTRL0, 32'h0000_0001);
    wait_q(1'b0, 8, t1);
    wr(srl_pkg::OFF_CTRL0, 32'h0000_0002);
    wait_q(1'b1, 8, t1);
    wr(srl_pkg::OFF_CTRL0, 32'h0000_00FF);
    wait_q(1'b0, 8, t1);
    rdchk("ctrl0 all", srl_pkg::OFF_CTRL0, 32'h0000_00FC, 1'b0);
    wr(srl_pkg::OFF_CTRL1, 32'h0000_00F0);
    rdchk("ctrl1 set half", srl_pkg::OFF_CTRL1, 32'h0000_00D0, 1'b0);
    wr(srl_pkg::OFF_CTRL1, 32'h0000_000F);
    rdchk("ctrl1 reset half", srl_pkg::OFF_CTRL1, 32'h0000_000D, 1'b0);
    wr(srl_pkg::OFF_CTRL1, 32'h0000_0000);
    for (int i = 0; i < 5; i++)
    begin
      wr(srl_pkg::OFF_CTRL0, 32'(en_tab[i]));
      @(negedge mclk_in);
      chk("true drive", 32'(en_tab[i][7] & en_tab[i][3]), 32'(tdrv));
      chk("inv drive", 32'(en_tab[i][7] & en_tab[i][2]), 32'(idrv));
      chk("inv level", 32'(!tq), 32'(iq));
    end
    for (int i = 0; i < 6; i++)
    begin
      wr(srl_pkg::OFF_CTRL0, se[i] ? 32'h0000_0001 : 32'h0000_0002);
      wait_q(~se[i], 8, t1);
      wr(srl_pkg::OFF_CTRL1, 32'(sc[i]));
      cmp_lvl <= sk[i][0];
      pin_lvl <= sk[i][1];
      wait_q(se[i], 1100, t1);
      @(posedge mclk_in);
      cmp_lvl <= 1'b0;
      pin_lvl <= 1'b0;
      repeat (8) @(negedge mclk_in);
      chk("hold", 32'(se[i]), 32'(tq));
      wr(srl_pkg::OFF_CTRL1, 32'h0000_0000);
    end
    wr(srl_pkg::OFF_CTRL0, 32'h0000_0001);
    wr(srl_pkg::OFF_SYNC, 32'h0000_0001);
    wr(srl_pkg::OFF_CTRL1, 32'h0000_0010);
    cmp_lvl <= 1'b1;
    repeat (20) @(negedge mclk_in);
    chk("timer still", 32'h0000_0000, 32'(tq));
    @(posedge mclk_in);
    trun <= 1'b1;
    wait_q(1'b1, 60, t1);
    @(posedge mclk_in);
    cmp_lvl <= 1'b0;
    trun    <= 1'b0;
    wr(srl_pkg::OFF_CTRL1, 32'h0000_0000);
    wr(srl_pkg::OFF_SYNC, 32'h0000_0000);
    for (int s = 0; s < 8; s++)
    begin
      p = 4 << s;
      wr(srl_pkg::OFF_CTRL0, 32'(s << 4) | 32'h0000_0001);
      wr(srl_pkg::OFF_CTRL1, 32'h0000_0040);
      wait_q(1'b1, 1100, t1);
      for (int k = 0; k < 2; k++)
      begin
        wr(srl_pkg::OFF_CTRL0, 32'(s << 4) | 32'h0000_0001);
        wait_q(1'b0, 8, t1);
        wait_q(1'b1, 1100, t1);
        c[k] = cyc;
      end
      d = c[1] - c[0];
      chk("period", 32'h0000_0001, 32'(d == p || (s == 0 && d == 2 * p)));
      wr(srl_pkg::OFF_CTRL1, 32'h0000_0000);
    end
    test_done();
  end
endmodule
`default_nettype wire
